// *** rtl/word_port_host.sv ***
// Purpose: host end issuing word reads and writes to the port
// Assumes: device acknowledges within the timeout
// Notes: a timeout ends a cycle and flags an error
`timescale 1ns/1ps
module word_port_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // host pins
  word_port_if.host bus,
  // user side
  input wire logic req,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic busy,
  output logic done,
  output logic timeout,
  output logic [15:0] rdata,
  output logic irq_seen
);
  typedef enum logic [1:0] {IDLE, STROBE, WAIT_ACK, RELEASE} hstate_t;
  hstate_t state;
  logic [7:0] timer;
  logic ack_s1, ack_s2;
  wire logic ack_seen = ~ack_s2;
  wire logic timer_out = timer == 8'(word_port_pkg::ACK_TIMEOUT);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
      irq_seen <= 1'b0;
      bus.dev_reset <= 1'b1;
    end else begin
      ack_s1 <= bus.transfer_done_ack_n;
      ack_s2 <= ack_s1;
      irq_seen <= bus.host_priority_level_inputs != 3'h0;
      bus.dev_reset <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
      timer <= word_port_pkg::TIMER_ZERO;
      bus.addr <= word_port_pkg::ADDR_RST;
      bus.address_valid_strobe_n <= word_port_pkg::STROBE_IDLE;
      bus.single_data_strobe_in_n <= word_port_pkg::STROBE_IDLE;
      bus.read_write_select <= word_port_pkg::RW_READ;
      bus.data_from_host <= word_port_pkg::DATA_RST;
      bus.data_oe_host <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      timeout <= 1'b0;
      rdata <= word_port_pkg::DATA_RST;
    end else begin
      done <= 1'b0;
      timeout <= 1'b0;
      case (state)
        IDLE: begin
          if (req) begin
            bus.addr <= {req_addr[15:1], word_port_pkg::ADDR_LSB_TIED};
            bus.read_write_select <= ~req_write;
            bus.data_from_host <= req_wdata;
            bus.data_oe_host <= req_write;
            busy <= 1'b1;
            timer <= word_port_pkg::TIMER_ZERO;
            state <= STROBE;
          end
        end
        STROBE: begin
          bus.address_valid_strobe_n <= 1'b0;
          bus.single_data_strobe_in_n <= 1'b0;
          state <= WAIT_ACK;
        end
        WAIT_ACK: begin
          timer <= timer + word_port_pkg::TIMER_ONE;
          if (ack_seen || timer_out) begin
            rdata <= bus.data_bus;
            timeout <= ~ack_seen;
            bus.address_valid_strobe_n <= word_port_pkg::STROBE_IDLE;
            bus.single_data_strobe_in_n <= word_port_pkg::STROBE_IDLE;
            state <= RELEASE;
          end
        end
        RELEASE: begin
          if (!ack_seen) begin
            bus.data_oe_host <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end
endmodule : word_port_host

// *** rtl/word_port_pkg.sv ***
// Purpose: shared constants for the asynchronous word-only host port
// Assumes: 16-bit data, word addressing, one system clock
// Notes: both ends use these names; the interface does not
package word_port_pkg;
  // ==========================================================
  // widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int SYNC_STAGES = 2;
  // ==========================================================
  // reset values and levels
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic ADDR_LSB_TIED = 1'b0;
  // ==========================================================
  // register space of the device end
  localparam int REG_DEPTH = 16;
  localparam int REG_IDX_W = 4;
  localparam int REG_IDX_LSB = 1;
  // ==========================================================
  // host timing, in cycles of sys_clk
  localparam int HOLD_CYCLES = 2;
  localparam int ACK_TIMEOUT = 64;
  localparam int TIMER_W = 8;
  localparam logic [7:0] TIMER_ZERO = 8'h00;
  localparam logic [7:0] TIMER_ONE = 8'h01;
endpackage : word_port_pkg

// *** rtl/word_port_if.sv ***
// Purpose: pins between the host processor and the word-only port
// Assumes: data bus resolved here from the two output enables
// Notes: the unused priority lines are encoded to zero here
`timescale 1ns/1ps
interface word_port_if;
  // ==========================================================
  // address and control
  logic [15:0] addr;
  logic address_valid_strobe_n;
  logic single_data_strobe_in_n;
  logic read_write_select;
  // ==========================================================
  // data bus, one driver per end
  logic [15:0] data_from_host;
  logic data_oe_host;
  logic [15:0] data_from_dev;
  logic data_oe_dev;
  wire [15:0] data_bus;
  // ==========================================================
  // answers from the device, and the device reset driven by the host
  logic transfer_done_ack_n;
  logic interrupt_request_out;
  logic dev_reset;
  wire [2:0] host_priority_level_inputs;

  assign data_bus = data_oe_dev ? data_from_dev :
                    (data_oe_host ? data_from_host : 16'h0000);
  assign host_priority_level_inputs = {2'b00, interrupt_request_out};

  modport dev (
    input addr, address_valid_strobe_n, single_data_strobe_in_n,
    input read_write_select, data_bus, dev_reset,
    output data_from_dev, data_oe_dev, transfer_done_ack_n,
    output interrupt_request_out
  );
  modport host (
    output addr, address_valid_strobe_n, single_data_strobe_in_n,
    output read_write_select, data_from_host, data_oe_host, dev_reset,
    input data_bus, transfer_done_ack_n, host_priority_level_inputs
  );
endinterface : word_port_if

// *** rtl/level_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous strobes
// Assumes: input may change at any time
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // level in and out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : level_sync

// *** rtl/word_port_device.sv ***
// Purpose: device end of the asynchronous word-only slave port
// Assumes: host keeps the address lsb low and uses one data strobe
// Notes: small register store stands in for the controller space
// Notes on behaviour
// - host keeps address lsb low always
// - decode only the sixteen low address lines
// - one data strobe, no byte lanes
// - host drives strobe from lower byte strobe
// - host must have a 16-bit bus
// - data lanes never byte swapped
// - slave only, no arbitration signals
// - single level interrupt, high means pending
// - host reads high line as priority request
// - reset input active high holds logic
// - host inverts its reset for device
// - address sampled only while strobe asserted
// - read high, write low picks direction
// - active-low acknowledge marks transfer done
`timescale 1ns/1ps
module word_port_device #(
  parameter int DEPTH = word_port_pkg::REG_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // host pins
  word_port_if.dev bus,
  // user side
  input wire logic irq_event,
  input wire logic irq_clear,
  output logic irq_pending,
  output logic [15:0] last_write_data,
  output logic write_pulse
);
  // ==========================================================
  // reset combine
  // reset input active high
  wire logic port_rst_n = rst_n & ~bus.dev_reset;

  // ==========================================================
  // strobe synchronisers
  logic [1:0] strobes_sync;
  level_sync #(.WIDTH(2)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(port_rst_n),
    .async_in({bus.address_valid_strobe_n, bus.single_data_strobe_in_n}),
    .sync_out(strobes_sync)
  );
  wire logic as_active = ~strobes_sync[1];
  wire logic ds_active = ~strobes_sync[0];

  // ==========================================================
  // decode
  logic [15:0] regs [DEPTH];
  // index from address lines 4..1 only
  wire logic [3:0] reg_idx =
    bus.addr[word_port_pkg::REG_IDX_LSB +: word_port_pkg::REG_IDX_W];
  wire logic cycle_go = as_active & ds_active;
  logic done;
  wire logic is_read = bus.read_write_select == word_port_pkg::RW_READ;
  wire logic next_wr = cycle_go & ~done & ~is_read;
  wire logic next_rd = cycle_go & ~done & is_read;

  // ==========================================================
  // transfer and acknowledge
  always_ff @(posedge sys_clk or negedge port_rst_n) begin
    if (!port_rst_n) begin
      done <= 1'b0;
      bus.transfer_done_ack_n <= word_port_pkg::STROBE_IDLE;
      bus.data_oe_dev <= 1'b0;
      bus.data_from_dev <= word_port_pkg::DATA_RST;
      write_pulse <= 1'b0;
      last_write_data <= word_port_pkg::DATA_RST;
    end else begin
      write_pulse <= next_wr;
      if (next_wr) begin
        regs[reg_idx] <= bus.data_bus;
        last_write_data <= bus.data_bus;
      end
      if (next_rd) begin
        bus.data_from_dev <= regs[reg_idx];
        bus.data_oe_dev <= 1'b1;
      end
      if (cycle_go & ~done) begin
        done <= 1'b1;
        bus.transfer_done_ack_n <= 1'b0;
      end else if (!ds_active) begin
        done <= 1'b0;
        bus.transfer_done_ack_n <= word_port_pkg::STROBE_IDLE;
        bus.data_oe_dev <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupt
  // level output, set wins clear
  always_ff @(posedge sys_clk or negedge port_rst_n) begin
    if (!port_rst_n) begin
      irq_pending <= 1'b0;
      bus.interrupt_request_out <= 1'b0;
    end else begin
      irq_pending <= irq_event | (irq_pending & ~irq_clear);
      bus.interrupt_request_out <= irq_event | (irq_pending & ~irq_clear);
    end
  end
  // no arbitration pins exist on this end
endmodule : word_port_device

// *** verification/word_port_props.sv ***
// Purpose: pin checks between host end and device end
// Assumes: one clock, pins sampled on its rising edge
// Notes: ack timing follows the two-flop strobe synchroniser
`timescale 1ns/1ps
module word_port_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // host pins
  input wire logic [15:0] addr,
  input wire logic address_valid_strobe_n,
  input wire logic single_data_strobe_in_n,
  input wire logic read_write_select,
  // device answers
  input wire logic data_oe_dev,
  input wire logic transfer_done_ack_n,
  input wire logic interrupt_request_out,
  input wire logic dev_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // steps of a transfer
  sequence ds_falls;
    $fell(single_data_strobe_in_n);
  endsequence
  sequence ack_in_time;
    ##[1:8] !transfer_done_ack_n;
  endsequence
  sequence ack_gone;
    ##[1:4] transfer_done_ack_n;
  endsequence
  // ==========================================================
  // host side
  lsb_low_a: assert property (!address_valid_strobe_n |-> !addr[0])
    else $error("address lsb high during a cycle");
  addr_hold_a: assert property (!address_valid_strobe_n &&
    $past(address_valid_strobe_n) == 1'b0 |-> $stable(addr))
    else $error("address moved under the strobe");
  ds_in_as_a: assert property (!single_data_strobe_in_n |->
    !address_valid_strobe_n) else $error("data strobe without address");
  // ==========================================================
  // device side; early ack would mean an unsynchronised strobe
  sync_wait_a: assert property (ds_falls |-> transfer_done_ack_n [*2])
    else $error("ack came before strobe sync");
  ack_bound_a: assert property (ds_falls |-> ack_in_time)
    else $error("no ack for a transfer");
  ack_cause_a: assert property ($fell(transfer_done_ack_n) |->
    $past(single_data_strobe_in_n, 2) == 1'b0)
    else $error("ack without a data strobe");
  ack_release_a: assert property ($rose(single_data_strobe_in_n) |->
    ack_gone) else $error("ack held after strobe release");
  read_dir_a: assert property (!transfer_done_ack_n && read_write_select
    |-> data_oe_dev) else $error("read ack without data drive");
  write_dir_a: assert property (!transfer_done_ack_n &&
    !read_write_select |-> !data_oe_dev) else $error("device drove on write");
  reset_quiet_a: assert property (dev_reset |-> !interrupt_request_out &&
    transfer_done_ack_n && !data_oe_dev) else $error("device active in reset");
endmodule : word_port_props

// *** verification/async_word_host_slave_port_test.sv ***
// Purpose: host end against device end, word reads and writes
// Assumes: store of 16 words indexed by address bits 4..1
// Notes: expected results queue up; a monitor compares on done
`timescale 1ns/1ps
module async_word_host_slave_port_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [15:0] req_addr = 16'h0000;
  logic [15:0] req_wdata = 16'h0000;
  logic irq_event = 1'b0;
  logic irq_clear = 1'b0;
  logic busy, done, timeout, irq_seen, irq_pending, write_pulse;
  logic [15:0] rdata, last_write_data, a;
  logic [15:0] mem [16];
  logic [16:0] exp_q [$];
  logic [16:0] note;
  logic to_seen = 1'b0;
  int wp_count = 0;
  int exp_writes = 0;
  int failures = 0;
  int comparisons = 0;
  int seed = 62;
  always #4 sys_clk = ~sys_clk;
  word_port_if bus_if ();
  word_port_device word_port_device_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(bus_if), .irq_event(irq_event), .irq_clear(irq_clear),
    .irq_pending(irq_pending), .last_write_data(last_write_data),
    .write_pulse(write_pulse));
  word_port_host word_port_host_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(bus_if), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .done(done), .timeout(timeout),
    .rdata(rdata), .irq_seen(irq_seen));
  word_port_props word_port_props_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .addr(bus_if.addr), .address_valid_strobe_n(bus_if.address_valid_strobe_n),
    .single_data_strobe_in_n(bus_if.single_data_strobe_in_n),
    .read_write_select(bus_if.read_write_select),
    .data_oe_dev(bus_if.data_oe_dev),
    .transfer_done_ack_n(bus_if.transfer_done_ack_n),
    .interrupt_request_out(bus_if.interrupt_request_out),
    .dev_reset(bus_if.dev_reset));
  // ==========================================================
  // checks and verdict
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task end_sim();
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // ==========================================================
  // one word transfer; upper address bits alias onto the store
  task do_op(input logic w, input logic [15:0] ad, input logic [15:0] d);
    int n;
    n = 0;
    if (w) mem[ad[4:1]] = d;
    if (w) exp_writes++;
    exp_q.push_back({w, w ? d : mem[ad[4:1]]});
    @(posedge sys_clk);
    #1;
    req = 1'b1;
    req_write = w;
    req_addr = ad;
    req_wdata = d;
    @(posedge sys_clk);
    #1;
    req = 1'b0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 100) begin
      // a hung handshake ends the run at the verdict
      failures++;
      end_sim();
    end
  endtask : do_op
  // interrupt level seen by device user, pins and host
  task irq_step(input logic ev, input logic cl, input logic [2:0] exp);
    @(posedge sys_clk);
    #1;
    irq_event = ev;
    irq_clear = cl;
    @(posedge sys_clk);
    #1;
    irq_event = 1'b0;
    irq_clear = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    chk({13'h0000, bus_if.host_priority_level_inputs}, {13'h0000, exp});
    chk({15'h0000, irq_seen}, {15'h0000, exp[0]});
    chk({15'h0000, irq_pending}, {15'h0000, exp[0]});
  endtask : irq_step
  // ==========================================================
  // monitor: oldest note against the finished transfer
  always @(posedge sys_clk) begin
    #2;
    if (timeout === 1'b1) to_seen = 1'b1;
    if (write_pulse === 1'b1) wp_count++;
    if (done === 1'b1) begin
      // no transfer may end by the host's timeout
      chk({15'h0000, to_seen}, 16'h0000);
      chk({15'h0000, busy}, 16'h0000);
      to_seen = 1'b0;
      note = exp_q.pop_front();
      if (note[16]) chk(last_write_data, note[15:0]);
      else chk(rdata, note[15:0]);
    end
  end
  initial begin
    #50000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    chk({15'h0000, bus_if.dev_reset}, 16'h0001);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 16; i++) begin
      do_op(1'b1, 16'(i * 2), 16'($random(seed)));
    end
    // random mix, back to back, over the whole 16-bit address range
    for (int i = 0; i < 40; i++) begin
      a = {15'($random(seed)), 1'b0};
      do_op(1'($random(seed)), a, 16'($random(seed)));
    end
    irq_step(1'b1, 1'b0, 3'b001);
    irq_step(1'b0, 1'b1, 3'b000);
    irq_step(1'b1, 1'b1, 3'b001);
    do_op(1'b0, 16'hFFFE, 16'h0000);
    irq_step(1'b0, 1'b1, 3'b000);
    chk(16'(wp_count), 16'(exp_writes));
    end_sim();
  end
endmodule : async_word_host_slave_port_test
